// [rtl/prsm_ratio_core.sv]
// ratio store, format, manual and automatic modifiers, and register slave
// Operation
// - each user ratio is a 32-bit unsigned fixed-point output to input ratio
// - four stored ratios; the two mode select pins choose the active one
// - a global format select reads the ratio as 12.20 or 20.12
// - high-resolution: upper 12 bits integer, lower 20 bits fraction
// - high-multiplication: upper 20 bits integer, lower 12 bits fraction
// - internal divider is compensated so stored ratio is only output over input
// - manual modifier scales the selected ratio, stored ratios stay untouched
// - manual select 00,01,10,11 gives 1/2, 1/4, 1/8, 1/16
// - manual modifier enabled only by the auxiliary pin under its function code
// - detector classes timing reference over input frequency as two-bit class
// - class 00 above 224 gives 1, 01 from 96 to 224 half, 10 below 96 quarter
// - automatic modifier enabled by modal bit or auxiliary pin under its code
// - automatic factor multiplies on top of manual factor, stored ratios unchanged
// - function 011: auxiliary pin high enables manual modifier, low disables
// - function 101: auxiliary pin overrides modal automatic enable
// - mode select pins also choose one of four modal parameter sets
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module prsm_ratio_core (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] mode_select_i,
  input wire logic aux_mode_pin_i,
  input wire logic clk_in_i,
  input prsm_pkg::prsm_bus_req_t bus_req_i,
  output prsm_pkg::prsm_bus_rsp_t bus_rsp_o,
  output prsm_pkg::prsm_ratio_out_t ratio_o,
  output prsm_pkg::prsm_rate_t input_rate_class_o
);
  import prsm_pkg::*;

  typedef struct packed {
    logic [NUM_RATIOS-1:0][31:0] stored_ratio_set;
    logic ratio_format_select;
    logic [2:0] aux_pin_function_cfg;
    logic [1:0] ref_div_select;
    logic [NUM_RATIOS-1:0][2:0] modal_set;
    logic [1:0] msel_s1;
    logic [1:0] msel_s2;
    logic aux_s1;
    logic aux_s2;
    logic clkin_s1;
    logic clkin_s2;
    prsm_phase_t phase;
    logic [DATA_W-1:0] rdata;
    logic [NORM_W-1:0] effective_ratio;
    logic [COMP_W-1:0] comp_ratio;
    logic man_act;
    logic auto_act;
  } prsm_core_state_t;

  prsm_core_state_t st_q;
  prsm_core_state_t st_d;
  prsm_rate_t rate_class;
  logic class_valid;
  logic bus_hit;
  logic [31:0] user_ratio;
  logic [2:0] modal_sel;
  logic [1:0] manual_modifier_select;
  logic auto_modifier_enable;
  logic man_en;
  logic auto_en;
  logic [2:0] man_shift;
  logic [2:0] auto_shift;
  logic [2:0] total_shift;
  logic [NORM_W-1:0] norm_ratio;
  logic [NORM_W-1:0] effective_ratio;
  logic [COMP_W-1:0] comp_ratio;

  prsm_rate_detect u_rate_detect (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .clk_in_sync_i(st_q.clkin_s2),
    .input_rate_class_o(rate_class),
    .class_valid_o(class_valid)
  );

  // byte lane merge for register writes
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // read multiplexer, unmapped offsets return zero
  function automatic logic [31:0] read_word(
    input prsm_core_state_t s,
    input logic [ADDR_W-1:0] addr,
    input prsm_rate_t rc,
    input logic cv
  );
    logic [31:0] res;
    res = 32'h0000_0000;
    unique case (addr)
      OFS_RATIO0: begin
        res = s.stored_ratio_set[0];
      end
      OFS_RATIO1: begin
        res = s.stored_ratio_set[1];
      end
      OFS_RATIO2: begin
        res = s.stored_ratio_set[2];
      end
      OFS_RATIO3: begin
        res = s.stored_ratio_set[3];
      end
      OFS_GLOBAL: begin
        res[GLB_FMT_BIT] = s.ratio_format_select;
        res[GLB_AUX_LSB +: 3] = s.aux_pin_function_cfg;
        res[GLB_DIV_LSB +: 2] = s.ref_div_select;
      end
      OFS_STATUS: begin
        res[STA_CLASS_LSB +: 2] = rc;
        res[STA_MSEL_LSB +: 2] = s.msel_s2;
        res[STA_MAN_BIT] = s.man_act;
        res[STA_AUTO_BIT] = s.auto_act;
        res[STA_VALID_BIT] = cv;
      end
      OFS_EFFECTIVE_RATIO_LO: begin
        res = s.effective_ratio[31:0];
      end
      OFS_EFFECTIVE_RATIO_HI: begin
        res[NORM_W-33:0] = s.effective_ratio[NORM_W-1:32];
      end
      OFS_COMP_LO: begin
        res = s.comp_ratio[31:0];
      end
      OFS_COMP_HI: begin
        res[COMP_W-33:0] = s.comp_ratio[COMP_W-1:32];
      end
      default: begin
        if (addr >= OFS_MODAL0 && addr <= OFS_MODAL3 && addr[1:0] == 2'b00) begin
          res[2:0] = s.modal_set[3'(addr[ADDR_W-1:2] - OFS_MODAL0[ADDR_W-1:2])];
        end
      end
    endcase
    return res;
  endfunction

  // ratio selection and modifier arithmetic
  always_comb begin
    user_ratio = st_q.stored_ratio_set[st_q.msel_s2];
    modal_sel = st_q.modal_set[st_q.msel_s2];
    manual_modifier_select = modal_sel[MOD_RMOD_LSB +: 2];
    auto_modifier_enable = modal_sel[MOD_AUTO_BIT];
    // manual factor only through the auxiliary pin
    man_en = (st_q.aux_pin_function_cfg == AUX_FN_RMOD) && st_q.aux_s2;
    if (st_q.aux_pin_function_cfg == AUX_FN_AUTO) begin
      auto_en = st_q.aux_s2;
    end else begin
      auto_en = auto_modifier_enable;
    end
    man_shift = 3'h0;
    if (man_en) begin
      man_shift = {1'b0, manual_modifier_select} + 3'h1;
    end
    auto_shift = 3'h0;
    if (auto_en) begin
      unique case (rate_class)
        RATE_SLOW: begin
          auto_shift = 3'h0;
        end
        RATE_MID: begin
          auto_shift = 3'h1;
        end
        RATE_FAST: begin
          auto_shift = 3'h2;
        end
        RATE_RSVD: begin
          auto_shift = 3'h0;
        end
      endcase
    end
    total_shift = man_shift + auto_shift;
    // bring both formats to one 20.20 scale
    if (st_q.ratio_format_select) begin
      norm_ratio = {{FMT_PAD{1'b0}}, user_ratio};
    end else begin
      norm_ratio = {user_ratio, {FMT_PAD{1'b0}}};
    end
    effective_ratio = norm_ratio >> total_shift;
    // reference divider folded in so stored ratio stays output over input
    comp_ratio = {{(COMP_W-NORM_W){1'b0}}, effective_ratio} << st_q.ref_div_select;
  end

  assign bus_hit = bus_req_i.read | bus_req_i.write;

  always_comb begin
    st_d = st_q;
    // two-stage synchronisers for the pins
    st_d.msel_s1 = mode_select_i;
    st_d.msel_s2 = st_q.msel_s1;
    st_d.aux_s1 = aux_mode_pin_i;
    st_d.aux_s2 = st_q.aux_s1;
    st_d.clkin_s1 = clk_in_i;
    st_d.clkin_s2 = st_q.clkin_s1;
    // result registers
    st_d.effective_ratio = effective_ratio;
    st_d.comp_ratio = comp_ratio;
    st_d.man_act = man_en;
    st_d.auto_act = auto_en;
    // bus slave: one wait cycle, then the answer
    unique case (st_q.phase)
      PH_IDLE: begin
        if (bus_hit) begin
          st_d.phase = PH_ANSWER;
          st_d.rdata = read_word(st_q, bus_req_i.address, rate_class, class_valid);
        end
      end
      PH_ANSWER: begin
        st_d.phase = PH_IDLE;
        if (bus_req_i.write) begin
          unique case (bus_req_i.address)
            OFS_RATIO0, OFS_RATIO1, OFS_RATIO2, OFS_RATIO3: begin
              st_d.stored_ratio_set[bus_req_i.address[3:2]] = be_merge(
                st_q.stored_ratio_set[bus_req_i.address[3:2]],
                bus_req_i.writedata, bus_req_i.byteenable);
            end
            OFS_GLOBAL: begin
              if (bus_req_i.byteenable[0]) begin
                st_d.ratio_format_select = bus_req_i.writedata[GLB_FMT_BIT];
                st_d.aux_pin_function_cfg = bus_req_i.writedata[GLB_AUX_LSB +: 3];
              end
              if (bus_req_i.byteenable[1]) begin
                st_d.ref_div_select = bus_req_i.writedata[GLB_DIV_LSB +: 2];
              end
            end
            default: begin
              if (bus_req_i.address >= OFS_MODAL0 && bus_req_i.address <= OFS_MODAL3
                  && bus_req_i.address[1:0] == 2'b00 && bus_req_i.byteenable[0]) begin
                st_d.modal_set[3'(bus_req_i.address[ADDR_W-1:2]
                  - OFS_MODAL0[ADDR_W-1:2])] = bus_req_i.writedata[2:0];
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
      st_q.stored_ratio_set <= {NUM_RATIOS{RATIO_RST}};
      st_q.ratio_format_select <= FMT_RST;
      st_q.aux_pin_function_cfg <= AUX_CFG_RST;
      st_q.ref_div_select <= DIV_RST;
      st_q.modal_set <= {NUM_RATIOS{MODAL_RST}};
      st_q.phase <= PH_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rsp_o.waitrequest = bus_hit && (st_q.phase == PH_IDLE);
  assign bus_rsp_o.readdata = st_q.rdata;
  assign ratio_o.effective = st_q.effective_ratio;
  assign ratio_o.compensated = st_q.comp_ratio;
  assign ratio_o.manual_active = st_q.man_act;
  assign ratio_o.auto_active = st_q.auto_act;
  assign input_rate_class_o = rate_class;

endmodule

// [rtl/prsm_pkg.sv]
// shared constants and carriers for the ratio select and modifier block
package prsm_pkg;

  // bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int NUM_RATIOS = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_RATIO0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_RATIO1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_RATIO2 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_RATIO3 = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_MODAL0 = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_MODAL3 = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_EFFECTIVE_RATIO_LO = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_EFFECTIVE_RATIO_HI = 6'h2c;
  localparam logic [ADDR_W-1:0] OFS_COMP_LO = 6'h30;
  localparam logic [ADDR_W-1:0] OFS_COMP_HI = 6'h34;

  // global configuration field positions
  localparam int GLB_FMT_BIT = 0;
  localparam int GLB_AUX_LSB = 4;
  localparam int GLB_DIV_LSB = 8;

  // modal configuration field positions
  localparam int MOD_RMOD_LSB = 0;
  localparam int MOD_AUTO_BIT = 2;

  // status field positions
  localparam int STA_CLASS_LSB = 0;
  localparam int STA_MSEL_LSB = 2;
  localparam int STA_MAN_BIT = 4;
  localparam int STA_AUTO_BIT = 5;
  localparam int STA_VALID_BIT = 6;

  // reset values
  localparam logic [31:0] RATIO_RST = 32'h0010_0000;
  localparam logic FMT_RST = 1'b1;
  localparam logic [2:0] AUX_CFG_RST = 3'h0;
  localparam logic [1:0] DIV_RST = 2'h0;
  localparam logic [2:0] MODAL_RST = 3'h0;

  // auxiliary pin function codes
  localparam logic [2:0] AUX_FN_RMOD = 3'b011;
  localparam logic [2:0] AUX_FN_AUTO = 3'b101;

  // range detector limits, in timing reference cycles per input period
  localparam int RATE_CNT_W = 8;
  localparam logic [RATE_CNT_W-1:0] RATE_HI_LIM = 8'd224;
  localparam logic [RATE_CNT_W-1:0] RATE_LO_LIM = 8'd96;
  localparam logic [RATE_CNT_W-1:0] RATE_CNT_MAX = 8'hff;

  // normalised ratio width: 20 integer bits, 20 fraction bits
  localparam int NORM_W = 40;
  localparam int COMP_W = 43;
  localparam int FMT_PAD = 8;

  typedef enum logic [1:0] {
    RATE_SLOW = 2'b00,
    RATE_MID = 2'b01,
    RATE_FAST = 2'b10,
    RATE_RSVD = 2'b11
  } prsm_rate_t;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_ANSWER = 1'b1
  } prsm_phase_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } prsm_bus_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } prsm_bus_rsp_t;

  typedef struct packed {
    logic [NORM_W-1:0] effective;
    logic [COMP_W-1:0] compensated;
    logic manual_active;
    logic auto_active;
  } prsm_ratio_out_t;

endpackage

// [rtl/prsm_rate_detect.sv]
// input frequency range detector counting timing reference cycles per input period
`timescale 1ns/1ns
module prsm_rate_detect (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic clk_in_sync_i,
  output prsm_pkg::prsm_rate_t input_rate_class_o,
  output logic class_valid_o
);
  import prsm_pkg::*;

  typedef struct packed {
    logic prev;
    logic seen_edge;
    logic [RATE_CNT_W-1:0] cnt;
    prsm_rate_t rate;
    logic valid;
  } prsm_det_state_t;

  prsm_det_state_t st_q;
  prsm_det_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.prev = clk_in_sync_i;
    if (st_q.cnt != RATE_CNT_MAX) begin
      st_d.cnt = st_q.cnt + 8'd1;
    end
    if (clk_in_sync_i && !st_q.prev) begin
      st_d.cnt = 8'd1;
      st_d.seen_edge = 1'b1;
      // a full period only after the first edge
      if (st_q.seen_edge) begin
        st_d.valid = 1'b1;
        if (st_q.cnt > RATE_HI_LIM) begin
          st_d.rate = RATE_SLOW;
        end else if (st_q.cnt >= RATE_LO_LIM) begin
          st_d.rate = RATE_MID;
        end else begin
          st_d.rate = RATE_FAST;
        end
      end
    end else if (st_q.cnt == RATE_CNT_MAX) begin
      // input stopped or period of 256 cycles or more, above the upper limit
      st_d.rate = RATE_SLOW;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign input_rate_class_o = st_q.rate;
  assign class_valid_o = st_q.valid;

endmodule

// [verification/prsm_ratio_core_monitor.sv]
// assertion checker on the ratio core ports
`timescale 1ns/1ns
module prsm_core_monitor (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] mode_select_i,
  input wire logic aux_mode_pin_i,
  input wire logic clk_in_i,
  input prsm_pkg::prsm_bus_req_t bus_req_i,
  input prsm_pkg::prsm_bus_rsp_t bus_rsp_o,
  input prsm_pkg::prsm_ratio_out_t ratio_o,
  input prsm_pkg::prsm_rate_t input_rate_class_o
);
  import prsm_pkg::*;
  logic [8:0] idle_q;
  logic last_q;
  // cycles since the input clock last moved, held at 300
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_q <= 9'h000;
      last_q <= 1'b0;
    end else begin
      last_q <= clk_in_i;
      if (clk_in_i != last_q) begin
        idle_q <= 9'h000;
      end else if (idle_q != 9'h12c) begin
        idle_q <= idle_q + 9'h001;
      end
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_wait_one: assert property ((bus_req_i.read || bus_req_i.write) && bus_rsp_o.waitrequest
    |=> !bus_rsp_o.waitrequest) else $error("wait longer than one cycle");
  a_wait_idle: assert property (!(bus_req_i.read || bus_req_i.write) |-> !bus_rsp_o.waitrequest)
    else $error("wait without request");
  a_class_legal: assert property (input_rate_class_o != RATE_RSVD)
    else $error("reserved rate class");
  a_manual_pin: assert property (ratio_o.manual_active |-> $past(aux_mode_pin_i, 3))
    else $error("manual modifier without pin");
  a_manual_half: assert property (ratio_o.manual_active |-> ratio_o.effective[39] == 1'b0)
    else $error("manual modifier did not halve");
  a_both_fast: assert property (ratio_o.manual_active && ratio_o.auto_active &&
    input_rate_class_o == RATE_FAST && $past(input_rate_class_o) == RATE_FAST
    |-> ratio_o.effective[39:37] == 3'h0) else $error("combined shift too small");
  a_comp_shift: assert property (ratio_o.compensated == {3'h0, ratio_o.effective} ||
    ratio_o.compensated == {2'h0, ratio_o.effective, 1'h0} ||
    ratio_o.compensated == {1'h0, ratio_o.effective, 2'h0} ||
    ratio_o.compensated == {ratio_o.effective, 3'h0}) else $error("compensation not a shift");
  a_idle_slow: assert property (idle_q == 9'h12c |-> input_rate_class_o == RATE_SLOW)
    else $error("stopped input not slow class");
  c_both: cover property (ratio_o.manual_active && ratio_o.auto_active);
  c_mid: cover property (input_rate_class_o == RATE_MID);
  c_fast: cover property (input_rate_class_o == RATE_FAST);
endmodule
bind prsm_ratio_core prsm_core_monitor u_mon (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .mode_select_i(mode_select_i), .aux_mode_pin_i(aux_mode_pin_i), .clk_in_i(clk_in_i),
  .bus_req_i(bus_req_i), .bus_rsp_o(bus_rsp_o), .ratio_o(ratio_o),
  .input_rate_class_o(input_rate_class_o));

// [verification/prsm_pin_model.sv]
// pin side partner: mode select, auxiliary pin and reference input clock
`timescale 1ns/1ns
module prsm_pin_model (
  input wire logic clk_sys_i,
  input wire logic [1:0] mode_req_i,
  input wire logic aux_req_i,
  input wire logic [7:0] half_period_i,
  output logic [1:0] mode_select_o,
  output logic aux_mode_pin_o,
  output logic clk_in_o
);
  logic [7:0] cnt_q;
  initial begin
    cnt_q = 8'h00;
    mode_select_o = 2'h0;
    aux_mode_pin_o = 1'b0;
    clk_in_o = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    mode_select_o <= mode_req_i;
    aux_mode_pin_o <= aux_req_i;
    if (half_period_i == 8'h00) begin
      cnt_q <= 8'h00;
      clk_in_o <= 1'b0;
    end else if (cnt_q + 8'h01 >= half_period_i) begin
      cnt_q <= 8'h00;
      clk_in_o <= !clk_in_o;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// [verification/pll_ratio_select_modifier_tb.sv]
// self-checking bench for the ratio select and modifier block
`timescale 1ns/1ns
module pll_ratio_select_modifier_tb;
  import prsm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  prsm_bus_req_t req = '0;
  prsm_bus_rsp_t rsp;
  prsm_ratio_out_t rat;
  prsm_rate_t cls;
  logic [1:0] mode_req = 2'h0;
  logic aux_req = 1'b0;
  logic [7:0] half_per = 8'h00;
  logic [1:0] msel;
  logic aux;
  logic cin;
  logic [31:0] expq[$];
  logic [31:0] seed = 32'h0000abcf;
  logic [31:0] ratios[4];
  logic [7:0] hps[4] = '{8'h00, 8'h96, 8'h50, 8'h14};
  int ash[4] = '{0, 0, 1, 2};
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clk_sys_i = !clk_sys_i;
  prsm_pin_model pins (.clk_sys_i(clk_sys_i), .mode_req_i(mode_req), .aux_req_i(aux_req),
    .half_period_i(half_per), .mode_select_o(msel), .aux_mode_pin_o(aux), .clk_in_o(cin));
  prsm_ratio_core dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mode_select_i(msel),
    .aux_mode_pin_i(aux), .clk_in_i(cin), .bus_req_i(req), .bus_rsp_o(rsp), .ratio_o(rat),
    .input_rate_class_o(cls));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    @(posedge clk_sys_i);
    while (rsp.waitrequest) @(posedge clk_sys_i);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic chk(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    expq.push_back(x);
    bus(1'b0, a, 32'h00000000);
  endtask
  task automatic chk_eff(input logic f, input logic [31:0] r, input int sh,
    input logic [1:0] dv);
    logic [39:0] e;
    logic [42:0] c;
    e = (f ? {8'h00, r} : {r, 8'h00}) >> sh;
    c = {3'h0, e} << dv;
    num_checks++;
    if (rat.effective !== e || rat.compensated !== c) begin
      miscompares++;
      $display("wrong value at %0t: ratio output %h", $time, rat.effective);
    end
    chk(OFS_EFFECTIVE_RATIO_LO, e[31:0]);
    chk(OFS_EFFECTIVE_RATIO_HI, {24'h000000, e[39:32]});
    chk(OFS_COMP_LO, c[31:0]);
    chk(OFS_COMP_HI, {21'h000000, c[42:32]});
  endtask
  // watcher: each answered read is compared with the oldest note
  always @(posedge clk_sys_i) begin
    if (req.read && !rsp.waitrequest) begin
      num_checks++;
      if (expq.size() == 0 || rsp.readdata !== expq[0]) begin
        miscompares++;
        $display("wrong value at %0t: read %h at %h", $time, rsp.readdata, req.address);
      end
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) chk(OFS_RATIO0 + 6'(4 * i), RATIO_RST);
    chk(OFS_GLOBAL, 32'h00000001);
    bus(1'b1, 6'h3c, rnd());
    chk(6'h3c, 32'h00000000);
    $display("test reset values done");
    for (int f = 0; f < 2; f++) begin
      for (int m = 0; m < 4; m++) begin
        ratios[m] = rnd();
        bus(1'b1, OFS_RATIO0 + 6'(4 * m), ratios[m]);
      end
      bus(1'b1, OFS_GLOBAL, {31'h0, f[0]});
      for (int m = 0; m < 4; m++) begin
        mode_req <= 2'(m);
        repeat (6) @(posedge clk_sys_i);
        chk_eff(f[0], ratios[m], 0, 2'h0);
      end
    end
    $display("test formats done");
    bus(1'b1, OFS_GLOBAL, 32'h00000231);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_MODAL0 + 6'(4 * m), 32'(m));
      mode_req <= 2'(m);
      aux_req <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      chk_eff(1'b1, ratios[m], m + 1, 2'h2);
      chk(OFS_RATIO0 + 6'(4 * m), ratios[m]);
      aux_req <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      chk_eff(1'b1, ratios[m], 0, 2'h2);
    end
    $display("test manual modifier done");
    bus(1'b1, OFS_MODAL0, 32'h00000005);
    mode_req <= 2'h0;
    aux_req <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      half_per <= hps[k];
      repeat (700) @(posedge clk_sys_i);
      chk_eff(1'b1, ratios[0], 2 + ash[k], 2'h2);
      chk(OFS_STATUS, 32'h30 | 32'(ash[k]) | (k > 0 ? 32'h40 : 32'h0));
      num_checks++;
      if (cls !== 2'(ash[k]) || rat.manual_active !== 1'b1
          || rat.auto_active !== 1'b1) begin
        miscompares++;
        $display("wrong value at %0t: class %h", $time, cls);
      end
    end
    bus(1'b1, OFS_GLOBAL, 32'h00000251);
    repeat (6) @(posedge clk_sys_i);
    chk_eff(1'b1, ratios[0], 2, 2'h2);
    aux_req <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk_eff(1'b1, ratios[0], 0, 2'h2);
    bus(1'b1, OFS_GLOBAL, 32'h00000201);
    repeat (6) @(posedge clk_sys_i);
    chk_eff(1'b1, ratios[0], 2, 2'h2);
    chk(OFS_RATIO0, ratios[0]);
    $display("test automatic modifier done");
    repeat (2) @(posedge clk_sys_i);
    conclude();
  end
endmodule
